// ---- rtl/ecpin_pkg.sv ----
package ecpin_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int LAMP_MS = 80;
	localparam int LAMP_CYCLES = (CLK_HZ / 1000) * LAMP_MS;
	localparam int WORD_ADDR_W = 7;
	localparam int HOST_DATA_W = 16;
	localparam int GP_PINS = 3;
	// word address of the first register location; below it lie the data fifo ports
	localparam logic [6:0] FIFO_TOP_ADDR = 7'h20;
	localparam logic [6:0] ENDIAN_TEST_ADDR = 7'h32;
	localparam logic [31:0] ENDIAN_TEST_VALUE = 32'h87654321;
	localparam int LAMP_SPEED = 0;
	localparam int LAMP_LINK = 1;
	localparam int LAMP_DUPLEX = 2;
	localparam logic SPEED_STRAP_RST = 1'b0;
	localparam logic EXT_PHY_STRAP_RST = 1'b0;

	typedef enum logic [1:0] {
		ECPIN_GP_INPUT = 2'h0,
		ECPIN_GP_PUSH_PULL = 2'h1,
		ECPIN_GP_OPEN_DRAIN = 2'h2,
		ECPIN_GP_LED = 2'h3
	} ecpin_gp_mode_t;

	typedef enum logic [1:0] {
		ECPIN_PROM_NORMAL = 2'h0,
		ECPIN_PROM_GPO = 2'h1,
		ECPIN_PROM_MON_EN = 2'h2,
		ECPIN_PROM_MON_CLK = 2'h3
	} ecpin_prom_mode_t;

	typedef enum logic [2:0] {
		ECPIN_LA_ON = 3'h1,
		ECPIN_LA_OFF = 3'h2,
		ECPIN_LA_HOLD = 3'h4
	} ecpin_la_state_t;
endpackage

// ---- rtl/ecpin_host_if.sv ----
// one taken host access, from the strobe front end to the word packer
interface ecpin_host_if;
	logic rd_pulse;
	logic wr_pulse;
	logic fifo_hit;
	logic [6:0] addr;
	logic [15:0] wdata;
	modport src (output rd_pulse, output wr_pulse, output fifo_hit, output addr, output wdata);
	modport dst (input rd_pulse, input wr_pulse, input fifo_hit, input addr, input wdata);
endinterface

// ---- rtl/ecpin_strobe.sv ----
// turns the sram-like strobes into one-cycle access pulses
module ecpin_strobe
	import ecpin_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic fifo_window_sel,
	input wire logic [6:0] word_addr,
	input wire logic [15:0] host_wdata,
	ecpin_host_if.src acc
);
	logic rd_q_ff;
	logic wr_q_ff;
	logic rd_now;
	logic wr_now;

	assign rd_now = !chip_select_n && !read_strobe_n;
	assign wr_now = !chip_select_n && !write_strobe_n;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q_ff <= 1'b0;
			wr_q_ff <= 1'b0;
		end else begin
			rd_q_ff <= rd_now;
			wr_q_ff <= wr_now;
		end
	end

	// a write is taken on its trailing edge, when the host data has settled
	assign acc.rd_pulse = rd_now && !rd_q_ff;
	assign acc.wr_pulse = !wr_now && wr_q_ff;
	assign acc.fifo_hit = fifo_window_sel || (word_addr < FIFO_TOP_ADDR);
	assign acc.addr = fifo_window_sel ? {5'h00, word_addr[1:0]} : word_addr;
	assign acc.wdata = host_wdata;
endmodule

// ---- rtl/ecpin_lamp.sv ----
// link and activity lamp: off-on flash with a guaranteed lit gap
module ecpin_lamp
	import ecpin_pkg::*;
#(
	parameter int HOLD_CYCLES = LAMP_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic link_up,
	input wire logic activity,
	output logic lamp_n
);
	ecpin_la_state_t state_ff;
	logic [31:0] cnt_ff;
	logic done;

	assign done = cnt_ff == 32'(HOLD_CYCLES - 1);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ECPIN_LA_ON;
			cnt_ff <= 32'h0;
		end else begin
			case (state_ff)
				ECPIN_LA_ON: begin
					cnt_ff <= 32'h0;
					if (link_up && activity) begin
						state_ff <= ECPIN_LA_OFF;
					end
				end
				ECPIN_LA_OFF: begin
					cnt_ff <= done ? 32'h0 : cnt_ff + 32'h1;
					if (done) begin
						state_ff <= ECPIN_LA_HOLD;
					end
				end
				ECPIN_LA_HOLD: begin
					cnt_ff <= done ? 32'h0 : cnt_ff + 32'h1;
					if (done) begin
						state_ff <= ECPIN_LA_ON;
					end
				end
				default: begin
					state_ff <= ECPIN_LA_ON;
					cnt_ff <= 32'h0;
				end
			endcase
		end
	end

	// lit (low) only with a link and outside the dark half of a flash
	assign lamp_n = !(link_up && state_ff != ECPIN_LA_OFF);
endmodule

// ---- rtl/ecpin_top.sv ----
// pin level glue: host port, straps, wake, lamps, general pins, mii and mgmt pins
module ecpin_top
#(
	parameter int LAMP_HOLD_CYCLES = ecpin_pkg::LAMP_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic fifo_window_sel,
	input wire logic [6:0] word_addr,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe,
	input wire logic big_endian,
	output logic [31:0] word_wdata,
	output logic word_wr,
	output logic word_rd,
	output logic word_fifo,
	output logic [6:0] word_addr_out,
	input wire logic [31:0] word_rdata,
	input wire logic reduced_power,
	output logic asleep,
	output logic read_done,
	input wire logic [1:0] irq_sources,
	input wire logic [1:0] irq_enable,
	input wire logic irq_active_high,
	input wire logic irq_open_drain,
	output logic irq_out,
	output logic irq_oe,
	input wire logic wake_event,
	input wire logic wake_enable,
	input wire logic wake_active_high,
	input wire logic wake_open_drain,
	output logic wake_indicator,
	output logic wake_indicator_oe,
	input wire logic speed_strap,
	output logic strap_speed_100,
	output logic strap_autoneg,
	output logic strap_full_duplex,
	input wire logic [1:0] prom_data_mode,
	input wire logic [1:0] prom_clock_mode,
	input wire logic output_only_bit_a,
	input wire logic output_only_bit_b,
	input wire logic prom_select_req,
	input wire logic prom_data_drive,
	input wire logic prom_data_out_val,
	input wire logic prom_clock_val,
	input wire logic int_tx_en,
	input wire logic int_tx_clk,
	input wire logic int_rx_dv,
	input wire logic int_rx_clk,
	input wire logic serial_prom_data_in,
	output logic serial_prom_data_out,
	output logic serial_prom_data_oe,
	output logic serial_prom_clock,
	output logic serial_prom_select_n,
	output logic prom_data_read,
	input wire logic [5:0] gp_mode,
	input wire logic [2:0] gp_out_val,
	input wire logic [2:0] gp_pin_in,
	output logic [2:0] gp_pin_out,
	output logic [2:0] gp_pin_oe,
	output logic [2:0] gp_in_val,
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic autoneg_busy,
	input wire logic full_duplex,
	input wire logic activity,
	input wire logic ext_phy_sel,
	input wire logic [3:0] mac_txd,
	input wire logic mac_tx_en,
	output logic [3:0] mii_txd,
	output logic mii_tx_en,
	input wire logic mgmt_port_select,
	input wire logic mgmt_clock_val,
	input wire logic mgmt_data_drive,
	input wire logic mgmt_data_val,
	input wire logic mgmt_data_pin_in,
	output logic mgmt_data_pin_out,
	output logic mgmt_data_pin_oe,
	output logic mgmt_clock_pin,
	output logic mgmt_data_read,
	output logic external_phy_strap
);
	import ecpin_pkg::*;

	ecpin_host_if acc ();
	logic asleep_ff;
	logic read_done_ff;
	logic half_ff;
	logic [15:0] low_half_ff;
	logic [31:0] rd_word_ff;
	logic rst_seen_ff;
	logic [15:0] nxt_rdata;
	logic wr_ok;
	logic led_lamp_n;
	logic [2:0] lamp_n;
	logic irq_level;
	logic wake_level;

	function automatic logic [15:0] ecpin_swap(input logic [15:0] v, input logic be);
		ecpin_swap = be ? {v[7:0], v[15:8]} : v;
	endfunction

	////////////////////////////////////////////////////////////////
	// host port

	ecpin_strobe u_strobe (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.chip_select_n(chip_select_n),
		.read_strobe_n(read_strobe_n),
		.write_strobe_n(write_strobe_n),
		.fifo_window_sel(fifo_window_sel),
		.word_addr(word_addr),
		.host_wdata(host_data_in),
		.acc(acc.src)
	);

	// writes are dead until a read has been seen since reset or wake
	assign wr_ok = acc.wr_pulse && read_done_ff && !asleep_ff;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			asleep_ff <= 1'b0;
		end else if (asleep_ff && acc.wr_pulse) begin
			asleep_ff <= 1'b0;
		end else if (reduced_power && !asleep_ff) begin
			asleep_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			read_done_ff <= 1'b0;
		end else if (acc.rd_pulse) begin
			read_done_ff <= 1'b1;
		end else if (asleep_ff) begin
			read_done_ff <= 1'b0;
		end
	end

	// the word pairs from two halves; bit 1 of the byte address picks the half
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			half_ff <= 1'b0;
			low_half_ff <= 16'h0000;
			word_wdata <= 32'h0;
			word_wr <= 1'b0;
			word_fifo <= 1'b0;
			word_addr_out <= 7'h00;
		end else begin
			word_wr <= 1'b0;
			if (wr_ok && !acc.addr[0]) begin
				low_half_ff <= ecpin_swap(acc.wdata, big_endian);
				half_ff <= 1'b1;
			end else if (wr_ok && acc.addr[0]) begin
				word_wdata <= {ecpin_swap(acc.wdata, big_endian), low_half_ff};
				word_wr <= half_ff;
				word_fifo <= acc.fifo_hit;
				word_addr_out <= {acc.addr[6:1], 1'b0};
				half_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			word_rd <= 1'b0;
			rd_word_ff <= 32'h0;
		end else begin
			word_rd <= acc.rd_pulse && !acc.addr[0];
			if (acc.rd_pulse && !acc.addr[0]) begin
				rd_word_ff <= word_rdata;
			end
		end
	end

	always_comb begin
		nxt_rdata = acc.addr[0] ? rd_word_ff[31:16] : word_rdata[15:0];
		nxt_rdata = ecpin_swap(nxt_rdata, big_endian);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			host_data_out <= 16'h0000;
			host_data_oe <= 1'b0;
		end else begin
			host_data_out <= nxt_rdata;
			host_data_oe <= !chip_select_n && !read_strobe_n;
		end
	end

	assign asleep = asleep_ff;
	assign read_done = read_done_ff;

	////////////////////////////////////////////////////////////////
	// interrupt and wake pins; open drain only ever drives the active level, released when inactive

	assign irq_level = |(irq_sources & irq_enable);
	assign wake_level = wake_enable && wake_event;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
			wake_indicator <= 1'b0;
			wake_indicator_oe <= 1'b0;
		end else begin
			irq_out <= irq_level == irq_active_high;
			irq_oe <= !irq_open_drain || irq_level;
			wake_indicator <= wake_level == wake_active_high;
			wake_indicator_oe <= !wake_open_drain || wake_level;
		end
	end

	////////////////////////////////////////////////////////////////
	// straps: speed and phy caught on the first clock after release, held until reset; full duplex strap held low

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_seen_ff <= 1'b0;
			strap_speed_100 <= SPEED_STRAP_RST;
			strap_autoneg <= SPEED_STRAP_RST;
			strap_full_duplex <= 1'b0;
			external_phy_strap <= EXT_PHY_STRAP_RST;
		end else begin
			rst_seen_ff <= 1'b1;
			strap_full_duplex <= 1'b0;
			if (!rst_seen_ff) begin
				strap_speed_100 <= speed_strap;
				strap_autoneg <= speed_strap;
				external_phy_strap <= mgmt_data_pin_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// serial prom pins

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_prom_select_n <= 1'b1;
			serial_prom_data_out <= 1'b0;
			serial_prom_data_oe <= 1'b0;
			serial_prom_clock <= 1'b0;
			prom_data_read <= 1'b0;
		end else begin
			serial_prom_select_n <= !(prom_select_req && prom_data_mode == ECPIN_PROM_NORMAL
				&& prom_clock_mode == ECPIN_PROM_NORMAL);
			prom_data_read <= (prom_data_mode == ECPIN_PROM_NORMAL) ? serial_prom_data_in : 1'b0;
			case (prom_data_mode)
				ECPIN_PROM_GPO: serial_prom_data_out <= output_only_bit_a;
				ECPIN_PROM_MON_EN: serial_prom_data_out <= int_tx_en;
				ECPIN_PROM_MON_CLK: serial_prom_data_out <= int_tx_clk;
				default: serial_prom_data_out <= prom_data_out_val;
			endcase
			serial_prom_data_oe <= (prom_data_mode != ECPIN_PROM_NORMAL) || prom_data_drive;
			case (prom_clock_mode)
				ECPIN_PROM_GPO: serial_prom_clock <= output_only_bit_b;
				ECPIN_PROM_MON_EN: serial_prom_clock <= int_rx_dv;
				ECPIN_PROM_MON_CLK: serial_prom_clock <= int_rx_clk;
				default: serial_prom_clock <= prom_clock_val;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// lamps and general pins

	ecpin_lamp #(
		.HOLD_CYCLES(LAMP_HOLD_CYCLES)
	) u_lamp (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.link_up(link_up),
		.activity(activity),
		.lamp_n(led_lamp_n)
	);

	assign lamp_n[LAMP_SPEED] = link_up && !speed_100 && !autoneg_busy;
	assign lamp_n[LAMP_LINK] = led_lamp_n;
	assign lamp_n[LAMP_DUPLEX] = !(link_up && full_duplex);

	genvar gi;
	generate
		for (gi = 0; gi < GP_PINS; gi++) begin : g_gp
			ecpin_gp_mode_t mode;
			assign mode = ecpin_gp_mode_t'(gp_mode[2 * gi +: 2]);
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					gp_pin_out[gi] <= 1'b0;
					gp_pin_oe[gi] <= 1'b0;
					gp_in_val[gi] <= 1'b0;
				end else begin
					gp_in_val[gi] <= gp_pin_in[gi];
					gp_pin_out[gi] <= 1'b0;
					case (mode)
						ECPIN_GP_PUSH_PULL: begin
							gp_pin_out[gi] <= gp_out_val[gi];
							gp_pin_oe[gi] <= 1'b1;
						end
						ECPIN_GP_OPEN_DRAIN: gp_pin_oe[gi] <= !gp_out_val[gi];
						ECPIN_GP_LED: gp_pin_oe[gi] <= !lamp_n[gi];
						default: gp_pin_oe[gi] <= 1'b0;
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// external mii and management pins

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			mii_txd <= 4'h0;
			mii_tx_en <= 1'b0;
			mgmt_data_pin_out <= 1'b0;
			mgmt_data_pin_oe <= 1'b0;
			mgmt_clock_pin <= 1'b0;
			mgmt_data_read <= 1'b0;
		end else begin
			mii_txd <= ext_phy_sel ? mac_txd : 4'h0;
			mii_tx_en <= ext_phy_sel && mac_tx_en;
			mgmt_data_pin_out <= mgmt_data_val;
			mgmt_data_pin_oe <= mgmt_port_select && mgmt_data_drive;
			mgmt_clock_pin <= mgmt_port_select && mgmt_clock_val;
			mgmt_data_read <= mgmt_port_select ? mgmt_data_pin_in : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	sequence s_wake_write;
		asleep_ff && acc.wr_pulse;
	endsequence

	property p_wake_on_write;
		@(posedge core_clk) disable iff (!reset_n) s_wake_write |=> !asleep_ff;
	endproperty
	a_wake_on_write: assert property (p_wake_on_write) else $error("no wake on write");

	property p_no_wake_by_event;
		@(posedge core_clk) disable iff (!reset_n)
			asleep_ff && !acc.wr_pulse |=> asleep_ff;
	endproperty
	a_no_wake_by_event: assert property (p_no_wake_by_event) else $error("woke without write");

	property p_write_needs_read;
		@(posedge core_clk) disable iff (!reset_n) !read_done_ff |=> !word_wr;
	endproperty
	a_write_needs_read: assert property (p_write_needs_read) else $error("write before read");

	property p_prom_select_off;
		@(posedge core_clk) disable iff (!reset_n)
			prom_data_mode != ECPIN_PROM_NORMAL |=> serial_prom_select_n;
	endproperty
	a_prom_select_off: assert property (p_prom_select_off) else $error("prom select active");

	property p_mii_quiet;
		@(posedge core_clk) disable iff (!reset_n) !ext_phy_sel |=> mii_txd == 4'h0 && !mii_tx_en;
	endproperty
	a_mii_quiet: assert property (p_mii_quiet) else $error("mii driven on internal phy");

	property p_mgmt_off;
		@(posedge core_clk) disable iff (!reset_n)
			!mgmt_port_select |=> !mgmt_clock_pin && !mgmt_data_pin_oe;
	endproperty
	a_mgmt_off: assert property (p_mgmt_off) else $error("mgmt pins active");

	property p_strap_hold;
		@(posedge core_clk) disable iff (!reset_n)
			rst_seen_ff ##1 rst_seen_ff |-> $stable(strap_speed_100) && $stable(external_phy_strap);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

	property p_irq_polarity;
		@(posedge core_clk) disable iff (!reset_n) irq_level |=> irq_out == $past(irq_active_high);
	endproperty
	a_irq_polarity: assert property (p_irq_polarity) else $error("irq polarity wrong");

	property p_fifo_window;
		@(posedge core_clk) disable iff (!reset_n)
			fifo_window_sel && wr_ok && acc.addr[0] |=> word_fifo && word_addr_out[6:2] == 5'h00;
	endproperty
	a_fifo_window: assert property (p_fifo_window) else $error("fifo window missed");
endmodule

// ---- verif/ecpin_host_model.sv ----
// host processor on the sram-like port: one access at a time, strobes rest high between
module ecpin_host_model (
	input wire logic core_clk,
	input wire logic [15:0] host_data_out,
	input wire logic host_data_oe,
	output logic chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [6:0] word_addr,
	output logic [15:0] host_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import ecpin_pkg::*;
	logic oe_seen;

	initial begin
		{chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
		word_addr = 7'h00;
		host_data_in = 16'h5a5a;
	end

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		tick();
		word_addr = a;
		chip_select_n = 1'b0;
		read_strobe_n = 1'b0;
		repeat (3) tick();
		d = host_data_out;
		oe_seen = host_data_oe;
		chip_select_n = 1'b1;
		read_strobe_n = 1'b1;
		tick();
	endtask

	// data stays put two edges past the strobe, as the write is taken on the trailing edge
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		tick();
		word_addr = a;
		host_data_in = d;
		chip_select_n = 1'b0;
		write_strobe_n = 1'b0;
		repeat (2) tick();
		chip_select_n = 1'b1;
		write_strobe_n = 1'b1;
		repeat (2) tick();
		host_data_in = ~d;
		tick();
	endtask

	task automatic wake();
		wr(ENDIAN_TEST_ADDR, 16'h4321);
	endtask
endmodule

// ---- verif/tb_ecpin_top.sv ----
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", n, e, a); end end

module tb_ecpin_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ecpin_pkg::*;
	localparam int LAMP = 8;
	int n_errors = 0;
	int total_checks = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	logic [31:0] last_w;
	logic last_f;
	logic core_clk, reset_n, fifo_window_sel, big_endian, reduced_power, speed_strap;
	logic irq_active_high, irq_open_drain, wake_event, wake_enable, wake_active_high;
	logic wake_open_drain, output_only_bit_a, output_only_bit_b, prom_select_req;
	logic prom_data_drive, prom_data_out_val, prom_clock_val, int_tx_en, int_tx_clk;
	logic int_rx_dv, int_rx_clk, link_up, speed_100, autoneg_busy, full_duplex, activity;
	logic ext_phy_sel, mac_tx_en, mgmt_port_select, mgmt_clock_val, mgmt_data_drive;
	logic mgmt_data_val, mdio_ext;
	logic [31:0] word_rdata;
	logic [1:0] irq_sources, irq_enable, prom_data_mode, prom_clock_mode;
	logic [5:0] gp_mode;
	logic [2:0] gp_out_val, gp_ext;
	logic [3:0] mac_txd;
	wire logic [2:0] gp_pin_in;
	wire logic mgmt_data_pin_in, serial_prom_data_in;
	logic chip_select_n, read_strobe_n, write_strobe_n;
	logic [6:0] word_addr, word_addr_out;
	logic [15:0] host_data_in, host_data_out;
	logic [31:0] word_wdata;
	logic host_data_oe, word_wr, word_rd, word_fifo, asleep, read_done, irq_out, irq_oe;
	logic wake_indicator, wake_indicator_oe, strap_speed_100, strap_autoneg;
	logic strap_full_duplex, serial_prom_data_out, serial_prom_data_oe, serial_prom_clock;
	logic serial_prom_select_n, prom_data_read, mii_tx_en, mgmt_data_pin_out;
	logic mgmt_data_pin_oe, mgmt_clock_pin, mgmt_data_read, external_phy_strap;
	logic [2:0] gp_pin_out, gp_pin_oe, gp_in_val;
	logic [3:0] mii_txd;

	ecpin_top #(.LAMP_HOLD_CYCLES(LAMP)) i_dut (.*);
	ecpin_host_model h (.*);

	// shared wires: whoever has the enable drives, otherwise the outside level shows
	assign gp_pin_in = (gp_pin_oe & gp_pin_out) | (~gp_pin_oe & gp_ext);
	assign mgmt_data_pin_in = mgmt_data_pin_oe ? mgmt_data_pin_out : mdio_ext;
	// no pull on the prom data line: released, it shows the inverse of the last drive
	assign serial_prom_data_in = serial_prom_data_oe ? serial_prom_data_out : ~serial_prom_data_out;

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (word_rd === 1'b1) rd_cnt++;
		if (word_wr === 1'b1) begin
			wr_cnt++;
			last_w = word_wdata;
			last_f = word_fifo;
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic t_reset(input logic s, input logic p);
		reset_n = 1'b0;
		speed_strap = s;
		mdio_ext = p;
		tick(2);
		`CHK("prom_sel_rst", 1'b1, serial_prom_select_n)
		`CHK("txen_rst", 1'b0, mii_tx_en)
		tick(3);
		reset_n = 1'b1;
		tick(2);
		speed_strap = ~s;
		mdio_ext = ~p;
		tick(3);
		`CHK("spd", s, strap_speed_100)
		`CHK("an", s, strap_autoneg)
		`CHK("fdx", 1'b0, strap_full_duplex)
		`CHK("phy", p, external_phy_strap)
		$display("test reset %0d done", s);
	endtask

	// writes before the first read must vanish; fifo window ignores the upper bits
	task automatic t_host(input logic be);
		logic [15:0] d;
		int n;
		int m;
		big_endian = be;
		n = wr_cnt;
		m = rd_cnt;
		h.wr(7'h30, 16'h1111);
		h.wr(7'h31, 16'h2222);
		`CHK("early_wr", n, wr_cnt)
		word_rdata = 32'hc3a5_1e69;
		h.rd(7'h30, d);
		`CHK("rdata", be ? 16'h691e : 16'h1e69, d)
		`CHK("rd_oe", 1'b1, h.oe_seen)
		`CHK("rd_done", 1'b1, read_done)
		// the high half must come from the word caught at the low-half read
		word_rdata = 32'h0;
		h.rd(7'h31, d);
		`CHK("rdata_hi", be ? 16'ha5c3 : 16'hc3a5, d)
		`CHK("word_rd", m + 1, rd_cnt)
		h.wr(7'h30, 16'h1234);
		h.wr(7'h31, 16'h5678);
		`CHK("nwr", n + 1, wr_cnt)
		`CHK("wdata", be ? 32'h7856_3412 : 32'h5678_1234, last_w)
		`CHK("reg_hit", 1'b0, last_f)
		`CHK("waddr", 7'h30, word_addr_out)
		fifo_window_sel = 1'b1;
		h.wr(7'h7c, 16'hbeef);
		h.wr(7'h7d, 16'hcafe);
		`CHK("fifo_hit", 1'b1, last_f)
		`CHK("fifo_addr", 7'h00, word_addr_out)
		fifo_window_sel = 1'b0;
		h.wr(7'h10, 16'h0001);
		h.wr(7'h11, 16'h0002);
		`CHK("low_fifo", 8'h90, {last_f, word_addr_out})
		$display("test host %0d done", be);
	endtask

	task automatic t_sleep();
		int n;
		reduced_power = 1'b1;
		tick(1);
		reduced_power = 1'b0;
		{wake_enable, wake_event, wake_active_high, wake_open_drain} = 4'b1110;
		tick(3);
		`CHK("asleep", 1'b1, asleep)
		`CHK("pme", 1'b1, wake_indicator)
		n = wr_cnt;
		h.wake();
		tick(1);
		`CHK("woke", 1'b0, asleep)
		h.wr(7'h30, 16'haaaa);
		h.wr(7'h31, 16'h5555);
		`CHK("wr_after_wake", n, wr_cnt)
		$display("test sleep done");
	endtask

	task automatic t_irqwake();
		for (int i = 0; i < 4; i++) begin
			{irq_active_high, irq_open_drain} = i[1:0];
			{wake_active_high, wake_open_drain} = i[1:0];
			{irq_sources, irq_enable, wake_event, wake_enable} = 6'b011010;
			tick(2);
			`CHK("irq_oe_off", !i[0], irq_oe)
			`CHK("pme_oe_off", !i[0], wake_indicator_oe)
			if (!i[0]) `CHK("irq_off", !i[1], irq_out)
			{irq_enable, wake_enable} = 3'b111;
			tick(2);
			`CHK("irq_on", i[1], irq_out)
			`CHK("irq_oe_on", 1'b1, irq_oe)
			`CHK("pme_on", i[1], wake_indicator)
			`CHK("pme_oe_on", 1'b1, wake_indicator_oe)
		end
		$display("test irq done");
	endtask

	task automatic t_prom();
		logic [3:0] dexp;
		logic [3:0] cexp;
		dexp = 4'b1010;
		cexp = 4'b0101;
		{prom_select_req, output_only_bit_a, output_only_bit_b, prom_clock_val} = 4'b1101;
		{int_tx_en, int_tx_clk, int_rx_dv, int_rx_clk} = 4'b0110;
		for (int m = 0; m < 4; m++) begin
			prom_data_mode = m[1:0];
			prom_clock_mode = m[1:0];
			tick(2);
			`CHK("prom_cs_n", m != 0, serial_prom_select_n)
			`CHK("prom_clk", cexp[m], serial_prom_clock)
			`CHK("prom_rd", m == 0, prom_data_read)
			if (m != 0) begin
				`CHK("prom_dat", dexp[m], serial_prom_data_out)
				`CHK("prom_oe", 1'b1, serial_prom_data_oe)
			end
		end
		$display("test prom done");
	endtask

	task automatic t_gp();
		int offn;
		int onn;
		gp_ext = 3'b101;
		gp_out_val = 3'b010;
		gp_mode = {ECPIN_GP_OPEN_DRAIN, ECPIN_GP_PUSH_PULL, ECPIN_GP_INPUT};
		tick(3);
		`CHK("gp_oe", 3'b110, gp_pin_oe)
		`CHK("gp_in", 1'b1, gp_in_val[0])
		gp_out_val = 3'b110;
		tick(2);
		`CHK("gp_od_rel", 3'b010, gp_pin_oe)
		gp_mode = {3{ECPIN_GP_LED}};
		{link_up, speed_100, autoneg_busy, full_duplex, activity} = 5'b10000;
		tick(3);
		`CHK("lamp_10m", 3'b010, gp_pin_oe)
		{speed_100, full_duplex} = 2'b11;
		tick(3);
		`CHK("lamp_100m", 3'b111, gp_pin_oe)
		`CHK("lamp_low", 3'b000, gp_pin_out & gp_pin_oe)
		{speed_100, autoneg_busy} = 2'b01;
		tick(3);
		`CHK("lamp_an", 1'b1, gp_pin_oe[0])
		offn = 0;
		onn = 0;
		activity = 1'b1;
		for (int c = 0; c < 60; c++) begin
			tick(1);
			if (gp_pin_oe[1] === 1'b0) begin
				if (onn > 0) break;
				offn++;
			end else if (offn > 0) onn++;
		end
		activity = 1'b0;
		`CHK("flash_off", LAMP, offn)
		`CHK("flash_gap", 1'b1, onn >= LAMP)
		$display("test gp done");
	endtask

	task automatic t_mii();
		{ext_phy_sel, mac_tx_en, mac_txd} = 6'h1a;
		{mgmt_port_select, mgmt_clock_val, mgmt_data_drive, mgmt_data_val} = 4'h7;
		tick(2);
		`CHK("mii_int", 5'h00, {mii_tx_en, mii_txd})
		`CHK("mdc_off", 1'b0, mgmt_clock_pin)
		`CHK("mdio_off", 2'b00, {mgmt_data_pin_oe, mgmt_data_read})
		{ext_phy_sel, mgmt_port_select} = 2'b11;
		tick(2);
		`CHK("mii_ext", 5'h1a, {mii_tx_en, mii_txd})
		`CHK("mdc_on", 1'b1, mgmt_clock_pin)
		`CHK("mdio_on", 3'b111, {mgmt_data_pin_oe, mgmt_data_pin_out, mgmt_data_read})
		$display("test mii done");
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		conclude();
	end

	initial begin
		core_clk = 1'b0;
		{reset_n, fifo_window_sel, big_endian, reduced_power, speed_strap, irq_active_high,
			irq_open_drain, wake_event, wake_enable, wake_active_high, wake_open_drain,
			output_only_bit_a, output_only_bit_b, prom_select_req, prom_data_drive,
			prom_data_out_val, prom_clock_val, int_tx_en, int_tx_clk, int_rx_dv, int_rx_clk,
			link_up, speed_100, autoneg_busy, full_duplex, activity, ext_phy_sel, mac_tx_en,
			mgmt_port_select, mgmt_clock_val, mgmt_data_drive, mgmt_data_val, mdio_ext,
			word_rdata, irq_sources, irq_enable, prom_data_mode, prom_clock_mode, gp_mode,
			gp_out_val, gp_ext, mac_txd} = '0;
		t_reset(1'b0, 1'b1);
		t_host(1'b0);
		t_reset(1'b1, 1'b0);
		t_host(1'b1);
		t_sleep();
		t_irqwake();
		t_prom();
		t_gp();
		t_mii();
		conclude();
	end
endmodule
